// File: hdl/gmhs_pkg.sv
package gmhs_pkg;
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned BAUD_DEFAULT  = 9600;
    localparam int unsigned CLKS_PER_BIT  = CLK_HZ / BAUD_DEFAULT;
    localparam int unsigned SEC_MS        = 1000;
    localparam int unsigned MARK_MS       = 100;
    localparam int unsigned FIX_MS        = 50;
    localparam int unsigned RUN_MS        = 1000;
    localparam int unsigned SLEEP_MS      = 4000;
    localparam int unsigned CLKS_PER_SEC  = CLK_HZ / 1000 * SEC_MS;
    localparam int unsigned MARK_CLKS     = CLK_HZ / 1000 * MARK_MS;
    localparam int unsigned FIX_CLKS      = CLK_HZ / 1000 * FIX_MS;
    localparam int unsigned RUN_CLKS      = CLK_HZ / 1000 * RUN_MS;
    localparam int unsigned SLEEP_CLKS    = CLK_HZ / 1000 * SLEEP_MS;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned FIFO_DEPTH    = 16;
    localparam logic [7:0]  CMD_STANDBY   = 8'h53;
    localparam logic [7:0]  CMD_PERIODIC  = 8'h50;
    localparam logic [1:0]  SETTLE_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        GMHS_IDLE  = 2'b00,
        GMHS_START = 2'b01,
        GMHS_DATA  = 2'b10,
        GMHS_STOP  = 2'b11
    } gmhs_bit_t;

    typedef struct packed {
        gmhs_bit_t   st;
        logic [15:0] cnt;
        logic [2:0]  idx;
        logic [7:0]  sh;
        logic        line;
    } gmhs_tx_t;

    typedef struct packed {
        gmhs_bit_t   st;
        logic [15:0] cnt;
        logic [2:0]  idx;
        logic [7:0]  sh;
        logic [7:0]  data;
        logic        done;
        logic        err;
    } gmhs_rx_t;

    localparam gmhs_tx_t TX_RESET = '{st: GMHS_IDLE, cnt: 16'h0000, idx: 3'h0,
                                      sh: 8'h00, line: 1'b1};
    localparam gmhs_rx_t RX_RESET = '{st: GMHS_IDLE, cnt: 16'h0000, idx: 3'h0,
                                      sh: 8'h00, data: 8'h00, done: 1'b0, err: 1'b0};

    // Idle high, one low start bit, eight bits LSB first, one high stop bit
    function automatic gmhs_tx_t tx_step(input gmhs_tx_t s, input logic go,
                                         input logic [7:0] d, input logic [15:0] cpb);
        gmhs_tx_t n;
        n = s;
        case (s.st)
            GMHS_IDLE: begin
                n.line = 1'b1;
                if (go) begin
                    n.st   = GMHS_START;
                    n.cnt  = 16'h0000;
                    n.sh   = d;
                    n.line = 1'b0;
                end
            end
            default: begin
                if (s.cnt == cpb - 16'h0001) begin
                    n.cnt = 16'h0000;
                    case (s.st)
                        GMHS_START: begin
                            n.st   = GMHS_DATA;
                            n.idx  = 3'h0;
                            n.line = s.sh[0];
                        end
                        GMHS_DATA: begin
                            if (s.idx == 3'h7) begin
                                n.st   = GMHS_STOP;
                                n.line = 1'b1;
                            end else begin
                                n.idx  = s.idx + 3'h1;
                                n.sh   = {1'b0, s.sh[7:1]};
                                n.line = s.sh[1];
                            end
                        end
                        default: begin
                            n.st   = GMHS_IDLE;
                            n.line = 1'b1;
                        end
                    endcase
                end else begin
                    n.cnt = s.cnt + 16'h0001;
                end
            end
        endcase
        return n;
    endfunction

    // Samples mid-bit; a start bit gone by its middle is a glitch and is dropped
    function automatic gmhs_rx_t rx_step(input gmhs_rx_t s, input logic in,
                                         input logic [15:0] cpb);
        gmhs_rx_t n;
        n      = s;
        n.done = 1'b0;
        n.err  = 1'b0;
        case (s.st)
            GMHS_IDLE: begin
                if (!in) begin
                    n.st  = GMHS_START;
                    n.cnt = 16'h0000;
                end
            end
            GMHS_START: begin
                if (s.cnt == (cpb >> 1) - 16'h0001) begin
                    n.cnt = 16'h0000;
                    n.idx = 3'h0;
                    n.st  = in ? GMHS_IDLE : GMHS_DATA;
                end else begin
                    n.cnt = s.cnt + 16'h0001;
                end
            end
            GMHS_DATA: begin
                if (s.cnt == cpb - 16'h0001) begin
                    n.cnt = 16'h0000;
                    n.sh  = {in, s.sh[7:1]};
                    n.idx = s.idx + 3'h1;
                    if (s.idx == 3'h7) begin
                        n.st = GMHS_STOP;
                    end
                end else begin
                    n.cnt = s.cnt + 16'h0001;
                end
            end
            default: begin
                if (s.cnt == cpb - 16'h0001) begin
                    n.cnt  = 16'h0000;
                    n.st   = GMHS_IDLE;
                    n.done = in;
                    n.err  = !in;
                    if (in) begin
                        n.data = s.sh;
                    end
                end else begin
                    n.cnt = s.cnt + 16'h0001;
                end
            end
        endcase
        return n;
    endfunction
endpackage

// File: hdl/gmhs_if.sv
`timescale 1ns/10ps
interface gmhs_if;
    logic serial_in;
    logic serial_out;
    logic reset_out;
    logic reset_oe;
    logic aux_standby_out;
    logic aux_standby_oe;
    logic second_mark_pulse;
    logic fix_indicator;
    // Undriven reset and aux pins float high through the module's pull-ups
    wire  reset_level       = reset_oe ? reset_out : 1'b1;
    wire  aux_standby_input = aux_standby_oe ? aux_standby_out : 1'b1;

    modport dev (
        input  serial_in,
        input  reset_level,
        input  aux_standby_input,
        output serial_out,
        output second_mark_pulse,
        output fix_indicator
    );

    modport host (
        output serial_in,
        output reset_out,
        output reset_oe,
        output aux_standby_out,
        output aux_standby_oe,
        input  serial_out,
        input  second_mark_pulse,
        input  fix_indicator
    );
endinterface

// File: hdl/gmhs_device.sv
`timescale 1ns/10ps
module gmhs_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   count;
    } gmhs_fifo_t;

    gmhs_fifo_t       st_r;
    gmhs_fifo_t       st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = st_r.count != (AW+1)'(DEPTH);
    assign out_valid = st_r.count != '0;
    assign out_data  = mem[st_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + AW'(1);
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + AW'(1);
        end
        st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end
endmodule

module gmhs_device #(
    parameter int unsigned CLKS_PER_BIT = gmhs_pkg::CLKS_PER_BIT,
    parameter int unsigned CLKS_PER_SEC = gmhs_pkg::CLKS_PER_SEC,
    parameter int unsigned MARK_CLKS    = gmhs_pkg::MARK_CLKS,
    parameter int unsigned FIX_CLKS     = gmhs_pkg::FIX_CLKS,
    parameter int unsigned RUN_CLKS     = gmhs_pkg::RUN_CLKS,
    parameter int unsigned SLEEP_CLKS   = gmhs_pkg::SLEEP_CLKS,
    parameter int unsigned FIFO_DEPTH   = gmhs_pkg::FIFO_DEPTH
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    gmhs_if.dev             link,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_frame_err,
    input  wire logic       fix_valid,
    input  wire logic       supply_low,
    input  wire logic       backup_supply,
    output logic            in_standby,
    output logic            periodic_mode,
    output logic            cold_start
);
    typedef struct packed {
        logic              rst_s1;
        logic              rst_s2;
        logic              low_s1;
        logic              low_s2;
        logic              bk_s1;
        logic              bk_s2;
        logic              rx_s1;
        logic              rx_s2;
        logic [1:0]        settle;
        logic              cold;
        gmhs_pkg::gmhs_tx_t tx;
        gmhs_pkg::gmhs_rx_t rx;
        logic [31:0]       sec;
        logic [31:0]       phase;
        logic              sleep;
        logic              periodic;
        logic              mark;
        logic              fix;
    } gmhs_dev_t;

    localparam logic [15:0] CPB = 16'(CLKS_PER_BIT);

    // Constant reset image keeps the asynchronous branch free of logic
    localparam gmhs_dev_t st_rst = '{rst_s1: 1'b1, rst_s2: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1,
                                     cold: 1'b1, tx: gmhs_pkg::TX_RESET,
                                     rx: gmhs_pkg::RX_RESET, default: '0};

    gmhs_dev_t  st_r;
    gmhs_dev_t  st_nxt;
    logic [7:0] q_data;
    logic       q_valid;
    logic       q_ready;
    logic       q_pop;
    logic       hold;

    // Draining stalls in standby, so the FIFO fills and back-pressures the user
    // Under hold the FIFO keeps its words: nothing is taken and nothing popped
    assign q_pop    = q_valid && !hold && !st_r.sleep && (st_r.tx.st == gmhs_pkg::GMHS_IDLE);
    assign hold     = !st_r.rst_s2 || st_r.low_s2;
    assign tx_ready = q_ready && !hold;

    gmhs_fifo #(
        .WIDTH     (gmhs_pkg::DATA_BITS),
        .DEPTH     (FIFO_DEPTH)
    ) u_txq (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (tx_data),
        .in_valid  (tx_valid && !hold),
        .in_ready  (q_ready),
        .out_data  (q_data),
        .out_valid (q_valid),
        .out_ready (q_pop)
    );

    always_comb begin
        st_nxt        = st_r;
        st_nxt.rst_s1 = link.reset_level;
        st_nxt.rst_s2 = st_r.rst_s1;
        st_nxt.low_s1 = supply_low;
        st_nxt.low_s2 = st_r.low_s1;
        st_nxt.bk_s1  = backup_supply;
        st_nxt.bk_s2  = st_r.bk_s1;
        st_nxt.rx_s1  = link.serial_in;
        st_nxt.rx_s2  = st_r.rx_s1;
        if (st_r.settle != gmhs_pkg::SETTLE_CYCLES) begin
            st_nxt.settle = st_r.settle + 2'h1;
            st_nxt.cold   = !st_r.bk_s2;
        end
        // Serial engines run side by side on separate lines
        st_nxt.tx = gmhs_pkg::tx_step(st_r.tx, q_pop, q_data, CPB);
        st_nxt.rx = gmhs_pkg::rx_step(st_r.rx, st_r.rx_s2, CPB);
        if (st_r.rx.done) begin
            st_nxt.sleep = 1'b0;
            st_nxt.phase = '0;
            if (st_r.rx.data == gmhs_pkg::CMD_STANDBY) begin
                st_nxt.sleep    = 1'b1;
                st_nxt.periodic = 1'b0;
            end else if (st_r.rx.data == gmhs_pkg::CMD_PERIODIC) begin
                st_nxt.periodic = 1'b1;
            end else begin
                st_nxt.periodic = 1'b0;
            end
        end else if (st_r.periodic) begin
            if (st_r.phase == 32'(st_r.sleep ? SLEEP_CLKS - 1 : RUN_CLKS - 1)) begin
                st_nxt.phase = '0;
                st_nxt.sleep = !st_r.sleep;
            end else begin
                st_nxt.phase = st_r.phase + 32'h1;
            end
        end
        st_nxt.sec  = (st_r.sec == 32'(CLKS_PER_SEC - 1)) ? '0 : st_r.sec + 32'h1;
        // A pulse only starts at the second boundary, so a wake never gives a late edge
        st_nxt.mark = !st_r.sleep && (st_nxt.sec < 32'(MARK_CLKS))
                      && (st_nxt.sec == '0 || st_r.mark);
        st_nxt.fix  = !st_r.sleep && fix_valid && (st_nxt.sec < 32'(FIX_CLKS))
                      && (st_nxt.sec == '0 || st_r.fix);
        if (hold) begin
            // Pin reset and brown-out both hold the core, syncs keep sampling
            st_nxt.settle = '0;
            st_nxt.cold   = st_rst.cold;
            st_nxt.tx     = st_rst.tx;
            st_nxt.rx     = st_rst.rx;
            st_nxt.sec    = '0;
            st_nxt.phase  = '0;
            st_nxt.sleep  = 1'b0;
            st_nxt.periodic = 1'b0;
            st_nxt.mark   = 1'b0;
            st_nxt.fix    = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= st_rst;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.serial_out        = st_r.tx.line;
    assign link.second_mark_pulse = st_r.mark;
    assign link.fix_indicator     = st_r.fix;
    assign rx_data                = st_r.rx.data;
    assign rx_valid               = st_r.rx.done;
    assign rx_frame_err           = st_r.rx.err;
    assign in_standby             = st_r.sleep;
    assign periodic_mode          = st_r.periodic;
    assign cold_start             = st_r.cold;
endmodule

// File: hdl/gmhs_host.sv
`timescale 1ns/10ps
module gmhs_host #(
    parameter int unsigned CLKS_PER_BIT = gmhs_pkg::CLKS_PER_BIT
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    gmhs_if.host            link,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_frame_err,
    input  wire logic       reset_req,
    output logic            mark_seen,
    output logic            fix_seen
);
    typedef struct packed {
        logic              rx_s1;
        logic              rx_s2;
        logic              pps_s1;
        logic              pps_s2;
        logic              pps_d;
        logic              fix_s1;
        logic              fix_s2;
        logic              mark;
        logic              rst_drive;
        gmhs_pkg::gmhs_tx_t tx;
        gmhs_pkg::gmhs_rx_t rx;
    } gmhs_host_t;

    localparam logic [15:0] CPB = 16'(CLKS_PER_BIT);

    // Constant reset image keeps the asynchronous branch free of logic
    localparam gmhs_host_t st_rst = '{rx_s1: 1'b1, rx_s2: 1'b1, tx: gmhs_pkg::TX_RESET,
                                      rx: gmhs_pkg::RX_RESET, default: '0};

    gmhs_host_t st_r;
    gmhs_host_t st_nxt;

    assign tx_ready = st_r.tx.st == gmhs_pkg::GMHS_IDLE;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.rx_s1     = link.serial_out;
        st_nxt.rx_s2     = st_r.rx_s1;
        st_nxt.pps_s1    = link.second_mark_pulse;
        st_nxt.pps_s2    = st_r.pps_s1;
        st_nxt.pps_d     = st_r.pps_s2;
        st_nxt.fix_s1    = link.fix_indicator;
        st_nxt.fix_s2    = st_r.fix_s1;
        st_nxt.mark      = st_r.pps_s2 && !st_r.pps_d;
        st_nxt.rst_drive = reset_req;
        st_nxt.tx = gmhs_pkg::tx_step(st_r.tx, tx_valid && tx_ready, tx_data, CPB);
        st_nxt.rx = gmhs_pkg::rx_step(st_r.rx, st_r.rx_s2, CPB);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= st_rst;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.serial_in       = st_r.tx.line;
    // Open drain: pull low on request, otherwise release the pin
    assign link.reset_out       = 1'b0;
    assign link.reset_oe        = st_r.rst_drive;
    assign link.aux_standby_out = 1'b0;
    assign link.aux_standby_oe  = 1'b0;
    assign rx_data              = st_r.rx.data;
    assign rx_valid             = st_r.rx.done;
    assign rx_frame_err         = st_r.rx.err;
    assign mark_seen            = st_r.mark;
    assign fix_seen             = st_r.fix_s2;
endmodule

// File: bench/gmhs_sva.sv
`timescale 1ns/10ps
module gmhs_sva #(
    parameter int unsigned CLKS_PER_SEC = 400,
    parameter int unsigned MARK_CLKS    = 40,
    parameter int unsigned FIX_CLKS     = 20
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic reset_out,
    input wire logic reset_oe,
    input wire logic reset_level,
    input wire logic aux_standby_oe,
    input wire logic second_mark_pulse,
    input wire logic fix_indicator
);
    logic [15:0] mark_hi_r;
    logic [15:0] fix_hi_r;
    logic [15:0] gap_r;
    logic        mark_d_r;

    // Gap saturates at one second; a reset through the pin sets it straight to one second
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mark_hi_r <= 16'h0000;
            fix_hi_r  <= 16'h0000;
            gap_r     <= 16'(CLKS_PER_SEC);
            mark_d_r  <= 1'b0;
        end else begin
            mark_hi_r <= second_mark_pulse ? mark_hi_r + 16'h0001 : 16'h0000;
            fix_hi_r  <= fix_indicator ? fix_hi_r + 16'h0001 : 16'h0000;
            mark_d_r  <= second_mark_pulse;
            if (!reset_level) begin
                gap_r <= 16'(CLKS_PER_SEC);
            end else if (second_mark_pulse && !mark_d_r) begin
                gap_r <= 16'h0001;
            end else if (gap_r < 16'(CLKS_PER_SEC)) begin
                gap_r <= gap_r + 16'h0001;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_aux_left_open: assert property (!aux_standby_oe)
        else $error("aux standby pin driven by host");
    chk_reset_open_drain: assert property (reset_oe |-> !reset_out)
        else $error("reset pin driven high");
    chk_reset_idle: assert property ($rose(rst_n) |-> serial_out && serial_in)
        else $error("serial lines not idle high after reset");
    chk_mark_width: assert property (second_mark_pulse |-> mark_hi_r < 16'(MARK_CLKS))
        else $error("second mark pulse too wide");
    chk_fix_width: assert property (fix_indicator |-> fix_hi_r < 16'(FIX_CLKS))
        else $error("fix indicator pulse too wide");
    chk_mark_period: assert property ($rose(second_mark_pulse) |-> gap_r == 16'(CLKS_PER_SEC))
        else $error("second mark rose before a full second");
    chk_hold_quiet: assert property ((!reset_level)[*6] |-> !second_mark_pulse && !fix_indicator)
        else $error("timing outputs active under pin reset");
    // Repetition counts assume the 16-cycle bit the bench runs with
    chk_tx_start_bit: assert property (disable iff (!rst_n || !reset_level)
        $fell(serial_out) |-> (!serial_out)[*8] ##1 (!serial_out)[*8])
        else $error("device start bit shorter than one bit");
    chk_rx_start_bit: assert property ($fell(serial_in) |-> (!serial_in)[*8] ##1 (!serial_in)[*8])
        else $error("host start bit shorter than one bit");

    cover property ($rose(second_mark_pulse));
    cover property ($rose(fix_indicator));
    cover property ($rose(reset_oe));
    cover property ($fell(serial_in));
endmodule

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
    localparam int unsigned CPB  = 16;
    localparam int unsigned SEC  = 400;
    localparam int unsigned MARK = 40;
    localparam int unsigned FIX  = 20;
    logic       ref_clk       = 1'b0;
    logic       rst_n         = 1'b0;
    logic [7:0] h_txd         = 8'h00;
    logic       h_txv         = 1'b0;
    logic [7:0] d_txd         = 8'h00;
    logic       d_txv         = 1'b0;
    logic       fix_valid     = 1'b0;
    logic       supply_low    = 1'b0;
    logic       backup_supply = 1'b0;
    logic       reset_req     = 1'b0;
    logic [7:0] h_rxd;
    logic [7:0] d_rxd;
    logic       h_rdy;
    logic       d_rdy;
    logic       h_rxv;
    logic       d_rxv;
    logic       in_standby;
    logic       periodic_mode;
    logic       cold_start;
    logic       h_mark;
    logic       h_fix;
    int         fails           = 0;
    int         samples_checked = 0;
    int         cycles          = 0;
    int         n;
    int         m;

    gmhs_if link_if ();
    gmhs_device #(.CLKS_PER_BIT(CPB), .CLKS_PER_SEC(SEC), .MARK_CLKS(MARK), .FIX_CLKS(FIX),
        .RUN_CLKS(200), .SLEEP_CLKS(300), .FIFO_DEPTH(16)) u_gmhs_device (
        .ref_clk(ref_clk), .rst_n(rst_n), .link(link_if), .tx_data(d_txd), .tx_valid(d_txv),
        .tx_ready(d_rdy), .rx_data(d_rxd), .rx_valid(d_rxv), .rx_frame_err(),
        .fix_valid(fix_valid), .supply_low(supply_low), .backup_supply(backup_supply),
        .in_standby(in_standby), .periodic_mode(periodic_mode), .cold_start(cold_start));
    gmhs_host #(.CLKS_PER_BIT(CPB)) u_gmhs_host (
        .ref_clk(ref_clk), .rst_n(rst_n), .link(link_if), .tx_data(h_txd), .tx_valid(h_txv),
        .tx_ready(h_rdy), .rx_data(h_rxd), .rx_valid(h_rxv), .rx_frame_err(),
        .reset_req(reset_req), .mark_seen(h_mark), .fix_seen(h_fix));
    gmhs_sva #(.CLKS_PER_SEC(SEC), .MARK_CLKS(MARK), .FIX_CLKS(FIX)) u_gmhs_sva (
        .ref_clk(ref_clk), .rst_n(rst_n), .serial_in(link_if.serial_in),
        .serial_out(link_if.serial_out), .reset_out(link_if.reset_out),
        .reset_oe(link_if.reset_oe), .reset_level(link_if.reset_level),
        .aux_standby_oe(link_if.aux_standby_oe),
        .second_mark_pulse(link_if.second_mark_pulse), .fix_indicator(link_if.fix_indicator));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("[FAIL] run time limit expected done seen hung");
            report_and_stop();
        end
    end

    function automatic logic sig(int sel);
        case (sel)
            0: sig = link_if.second_mark_pulse;
            1: sig = link_if.fix_indicator;
            2: sig = in_standby;
            3: sig = d_rxv;
            4: sig = h_rxv;
            5: sig = link_if.serial_in;
            6: sig = link_if.serial_out;
            7: sig = h_rdy;
            default: sig = d_rdy;
        endcase
    endfunction

    // All driving and sampling happens 1 ns after the edge, once registers settle
    task automatic step(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (exp !== got) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_for(int sel, logic val, int lim, output int k);
        k = 0;
        while (sig(sel) !== val && k < lim) begin
            step(1);
            k++;
        end
        if (k == lim) check("bounded wait", val, sig(sel));
    endtask

    task automatic push(int sel, logic [7:0] b);
        int k;
        step(1);
        if (sel == 1) begin
            d_txd = b;
            d_txv = 1'b1;
        end else begin
            h_txd = b;
            h_txv = 1'b1;
        end
        wait_for(sel == 1 ? 8 : 7, 1'b1, 400, k);
        step(1);
        if (sel == 1) begin
            d_txv = 1'b0;
        end else begin
            h_txv = 1'b0;
        end
    endtask

    task automatic expect_rx(int sel, logic [7:0] b);
        int k;
        step(1);
        wait_for(sel, 1'b1, 400, k);
        check("received byte", b, sel == 3 ? d_rxd : h_rxd);
    endtask

    task automatic wire_check(int sel, logic [7:0] b);
        int k;
        wait_for(sel, 1'b0, 2000, k);
        step(CPB / 2);
        check("start bit", 0, sig(sel));
        for (int i = 0; i < 8; i++) begin
            step(CPB);
            check("data bit", b[i], sig(sel));
        end
        step(CPB);
        check("stop bit", 1, sig(sel));
    endtask

    task automatic count_high(int sel, int cyc, output int k);
        k = 0;
        repeat (cyc) begin
            step(1);
            if (sig(sel) === 1'b1) k++;
        end
    endtask

    initial begin
        step(16);
        rst_n = 1'b1;
        step(1);
        check("cold start", 1, cold_start);
        check("standby after reset", 0, in_standby);
        check("default bit period", 20833, 16'(gmhs_pkg::CLKS_PER_BIT));
        check("reset pin undriven", 1, link_if.reset_level);
        check("aux pin undriven", 0, link_if.aux_standby_oe);
        fork
            push(0, 8'hc3);
            push(1, 8'h3c);
            expect_rx(3, 8'hc3);
            expect_rx(4, 8'h3c);
            wire_check(5, 8'hc3);
            wire_check(6, 8'h3c);
        join
        count_high(1, 450, n);
        check("fix without fix", 0, n);
        fix_valid = 1'b1;
        wait_for(0, 1'b1, 450, n);
        wait_for(0, 1'b0, 60, n);
        check("mark width", MARK, n);
        wait_for(0, 1'b1, 450, m);
        check("mark period", SEC, n + m);
        // Host edge detector sits behind a two-stage sync and one register
        step(3);
        check("mark seen", 1, h_mark);
        wait_for(1, 1'b0, 60, n);
        wait_for(1, 1'b1, 450, n);
        wait_for(1, 1'b0, 60, n);
        check("fix width", FIX, n);
        wait_for(1, 1'b1, 450, m);
        check("fix period", SEC, n + m);
        step(2);
        check("fix seen", 1, h_fix);
        push(0, gmhs_pkg::CMD_STANDBY);
        expect_rx(3, gmhs_pkg::CMD_STANDBY);
        step(2);
        check("enter standby", 1, in_standby);
        // Drain is stalled in standby, so sixteen pushes must fill the buffer
        for (int i = 0; i < 16; i++) push(1, 8'(8'h40 + i));
        step(1);
        check("full buffer refuses", 0, d_rdy);
        push(0, 8'h11);
        expect_rx(3, 8'h11);
        step(2);
        check("wake on byte", 0, in_standby);
        for (int i = 0; i < 16; i++) expect_rx(4, 8'(8'h40 + i));
        push(0, gmhs_pkg::CMD_PERIODIC);
        expect_rx(3, gmhs_pkg::CMD_PERIODIC);
        step(2);
        check("periodic on", 1, periodic_mode);
        wait_for(2, 1'b1, 260, n);
        wait_for(2, 1'b0, 360, n);
        check("sleep interval", 300, n);
        wait_for(2, 1'b1, 260, n);
        check("run interval", 200, n);
        check("run sleep run sleep", 1, in_standby);
        push(0, 8'h00);
        expect_rx(3, 8'h00);
        step(2);
        check("periodic off", 0, periodic_mode);
        backup_supply = 1'b1;
        reset_req = 1'b1;
        step(2);
        check("reset pin low", 0, link_if.reset_level);
        step(6);
        check("held refuses", 0, d_rdy);
        check("line idle in hold", 1, link_if.serial_out);
        reset_req = 1'b0;
        step(10);
        check("warm start", 0, cold_start);
        check("pin released", 0, link_if.reset_oe);
        supply_low = 1'b1;
        step(8);
        check("low supply holds", 0, d_rdy);
        supply_low = 1'b0;
        step(8);
        check("low supply ends", 1, d_rdy);
        report_and_stop();
    end
endmodule
